// File: rtl/mds_pkg.sv
// Purpose: Shared constants for the motor driver serial register block
// Assumes: 40 MHz system clock, mode 0 serial link, 8-bit registers
// Notes:   Offsets, field positions, reset values and timing live here
package mds_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Packet layout
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [4:0] PACKET_BITS = 5'h10;
  localparam int unsigned OP_BIT = 7;
  localparam int unsigned ADDR_MSB = 4;

  // Register offsets
  localparam logic [4:0] OFS_WATCHDOG = 5'h00;
  localparam logic [4:0] OFS_STEP_CUR = 5'h01;
  localparam logic [4:0] OFS_DRIVE = 5'h02;
  localparam logic [4:0] OFS_POWER = 5'h03;
  localparam logic [4:0] OFS_STATUS0 = 5'h04;
  localparam int unsigned NUM_CTRL = 4;
  localparam int unsigned NUM_STAT = 4;

  // Reset value of every control and status register
  localparam logic [7:0] RST_REG = 8'h00;

  // Writable bits per control register, unused bits read zero
  localparam logic [3:0][7:0] CTRL_MASK = {8'hF0, 8'hF3, 8'hFF, 8'hF8};

  // Watchdog register fields
  localparam int unsigned WD_EN_BIT = 7;
  localparam int unsigned WD_TO_MSB = 6;
  localparam int unsigned WD_TO_LSB = 3;
  // Stepping and current fields
  localparam int unsigned SM_MSB = 7;
  localparam int unsigned SM_LSB = 5;
  localparam int unsigned CUR_MSB = 4;
  localparam int unsigned CUR_LSB = 0;
  // Drive option fields
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned STEP_POL_BIT = 6;
  localparam int unsigned PWM_DBL_BIT = 5;
  localparam int unsigned PWM_JIT_BIT = 4;
  localparam int unsigned SLOPE_MSB = 1;
  localparam int unsigned SLOPE_LSB = 0;
  // Power and load angle fields
  localparam int unsigned MOT_EN_BIT = 7;
  localparam int unsigned SLEEP_BIT = 6;
  localparam int unsigned LA_GAIN_BIT = 5;
  localparam int unsigned LA_HOLD_BIT = 4;
  // Boot flag position inside status register zero
  localparam int unsigned BOOT_FLAG_BIT = 4;

  // Watchdog time base: one unit per timeout step
  localparam int unsigned WD_UNIT_MS = 32;
  localparam int unsigned WD_UNIT_CYC = WD_UNIT_MS * (CLK_HZ / 1000);

  // PWM base rate, period rounded down to whole cycles
  localparam int unsigned PWM_BASE_HZ = 22_800;
  localparam int unsigned PWM_CYC = CLK_HZ / PWM_BASE_HZ;
  localparam int unsigned PWM_W = 12;

  // Load angle gain shifts: 0.5 and 0.25
  localparam int unsigned LA_SHIFT_HALF = 1;
  localparam int unsigned LA_SHIFT_QUARTER = 2;

  // Watchdog states
  typedef enum logic [1:0] {
    WD_IDLE = 2'b01,
    WD_RUN = 2'b10
  } mds_wd_state_t;

endpackage

// File: rtl/mds_spi_link.sv
// Purpose: Serial link end running on the master's serial clock
// Assumes: Mode 0, MSB first, clock idles low, image stable in frame
// Notes:   Image words only change while chip select is high
`timescale 1ns/10ps
module mds_spi_link (
  input wire logic sclk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_in,
  input wire logic [63:0] image_in,
  output logic [7:0] cmd_byte_out,
  output logic [7:0] data_byte_out,
  output logic len_ok_out,
  output logic frame_tog_out,
  output logic serial_out_out
);

  logic frame_rst_n; // Frame flag cleared while deselected
  logic in_frame_q; // A rising edge seen in this frame
  logic [2:0] bit_idx_q; // Bit position within the byte
  logic [4:0] len_q; // Saturating frame length
  logic [4:0] len_d;
  logic [7:0] shift_q; // Receive shifter
  logic [7:0] rx_byte; // Byte as completed by this edge
  logic [7:0] out_q; // Transmit shifter
  logic [4:0] ptr_q; // Last received address
  logic expect_data_q; // Next byte is write data
  logic boundary; // Eighth falling edge of a byte

  assign frame_rst_n = rst_n_in & ~chip_select_n_in;
  assign rx_byte = {shift_q[6:0], serial_in_in};
  assign boundary = in_frame_q && (bit_idx_q == 3'h0);
  assign serial_out_out = out_q[7];

  // Length restarts at frame start and saturates
  always_comb begin
    if (!in_frame_q) begin
      len_d = 5'h01;
    end else if (len_q == 5'h1F) begin
      len_d = len_q;
    end else begin
      len_d = len_q + 5'h01;
    end
  end

  // Frame flag, reset by chip select going high
  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  // Receive side on rising edges; length counted for validation
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_idx_q <= 3'h0;
      len_q <= 5'h00;
      shift_q <= 8'h00;
      cmd_byte_out <= 8'h00;
      data_byte_out <= 8'h00;
      len_ok_out <= 1'b0;
      frame_tog_out <= 1'b0;
    end else begin
      bit_idx_q <= in_frame_q ? bit_idx_q + 3'h1 : 3'h1;
      len_q <= len_d;
      shift_q <= rx_byte;
      if (len_d == 5'h08) begin
        cmd_byte_out <= rx_byte;
      end
      if (len_d == mds_pkg::PACKET_BITS) begin
        data_byte_out <= rx_byte;
      end
      len_ok_out <= (len_d == mds_pkg::PACKET_BITS);
      if (!in_frame_q) begin
        frame_tog_out <= ~frame_tog_out;
      end
    end
  end

  // Transmit side: reload only at byte ends, shift otherwise
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q <= 8'h00;
      ptr_q <= 5'h00;
      expect_data_q <= 1'b0;
    end else if (boundary) begin
      if (expect_data_q) begin
        expect_data_q <= 1'b0;
        out_q <= (ptr_q[4:3] == 2'h0) ?
          image_in[{ptr_q[2:0], 3'h0} +: 8] : 8'h00;
      end else begin
        ptr_q <= shift_q[4:0];
        expect_data_q <= shift_q[mds_pkg::OP_BIT];
        out_q <= (shift_q[4:3] == 2'h0) ?
          image_in[{shift_q[2:0], 3'h0} +: 8] : 8'h00;
      end
    end else begin
      out_q <= {out_q[6:0], 1'b0};
      if (len_q == 5'h01) begin
        expect_data_q <= 1'b0;
      end
    end
  end

  // Transmit buffer never reloads away from a byte end
  shift_only_a: assert property (
    @(negedge sclk_in) disable iff (!rst_n_in)
    (in_frame_q && bit_idx_q != 3'h0) |=>
      (out_q == {$past(out_q[6:0]), 1'b0}))
    else $error("transmit buffer loaded mid byte");

endmodule

// File: rtl/mds_motor_spi_regs.sv
// Purpose: Serial slave write path and control registers of a driver
// Assumes: Master clocks the link; system clock 40 MHz
// Notes:   Writes commit on the system clock once chip select is high
`timescale 1ns/10ps
// Function
// - Write data commits only after select rises
// - Each byte returns last addressed register contents
// - Write packet must be exactly sixteen bits
// - Writes to read-only registers change nothing
// - Address pointer unknown after reset; ignore first (reset here clears pointer to zero, first byte reads 00)
// - Write data byte returns previous register contents
// - Read after write returns old value first
// - Status updates only while select is high
// - Transmit buffer loads only on eighth falling edges
// - Control registers read, write, reset to zero
// - Watchdog enable one starts or restarts timer
// - Watchdog enable zero clears the boot flag
// - Step mode high bits, current low bits
// - Direction, polarity, PWM double, jitter, slope fields
// - Motor enable, sleep, gain, transparency, four unused
// - Transparency bit zero lets load angle follow
// - Gain bit selects half or quarter gain
// - PWM rate base or doubled by bit
// - Jitter bit enables PWM period jitter
// - Sleep bit selects active or sleep mode
// - Watchdog timeout is 32 ms times setting+1
// - First byte bit seven write, low five address
// - Sleep ignores step and direction, keeps registers
// - Motor enable bit gates driver outputs
module mds_motor_spi_regs #(
  parameter int unsigned WD_UNIT_CYC = mds_pkg::WD_UNIT_CYC,
  parameter int unsigned LA_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_in,
  input wire logic step_input_in,
  input wire logic direction_in,
  input wire logic [LA_W-1:0] load_angle_in,
  input wire logic [27:0] status_bits_in,
  output logic serial_out_out,
  output logic serial_out_en_out,
  output logic [2:0] step_mode_sel_out,
  output logic [4:0] current_amplitude_sel_out,
  output logic [1:0] slope_control_out,
  output logic step_pulse_out,
  output logic direction_out,
  output logic pwm_tick_out,
  output logic sleep_out,
  output logic driver_enable_out,
  output logic [LA_W-1:0] load_angle_output_out,
  output logic watchdog_reset_out,
  output logic boot_flag_out
);

  localparam int UC_W = $clog2(WD_UNIT_CYC + 1);

  // Register banks, packed so they form the read image directly
  logic [3:0][7:0] ctrl_q; // Control registers
  logic [3:0][7:0] stat_q; // Status registers with parity
  logic [3:0][6:0] stat_raw; // Status payload before parity
  logic [63:0] image; // Readable image for the link

  // Link results, quasi-static once the frame has ended
  logic [7:0] cmd_byte;
  logic [7:0] data_byte;
  logic len_ok;
  logic frame_tog;

  // Synchronisers for pins and the frame toggle
  logic cs_meta_q, cs_sync_q, cs_prev_q;
  logic tog_meta_q, tog_sync_q, tog_seen_q;
  logic step_meta_q, step_sync_q, step_prev_q;
  logic dir_meta_q, dir_sync_q;

  // Commit decode
  logic cs_rise; // Select returned high
  logic new_frame; // A clocked frame preceded the rise
  logic wr_hit; // Valid write to a control register
  logic [1:0] wr_addr;
  logic wd_kick; // Enable written as one
  logic wd_boot_clr; // Enable written as zero

  // Watchdog
  mds_pkg::mds_wd_state_t wd_state_q;
  logic [UC_W-1:0] wd_unit_q; // Cycles within one unit
  logic [3:0] wd_units_q; // Units elapsed
  logic wd_unit_done;
  logic wd_expire;
  logic boot_flag_q;

  // Motion and PWM
  logic sleep;
  logic step_edge;
  logic [mds_pkg::PWM_W-1:0] pwm_cnt_q;
  logic [mds_pkg::PWM_W-1:0] pwm_limit;
  logic [7:0] lfsr_q; // Jitter source
  logic [LA_W-1:0] la_scaled;

  // Link end on the master's clock
  mds_spi_link u_link (
    .sclk_in(sclk_in),
    .rst_n_in(rst_n_in),
    .chip_select_n_in(chip_select_n_in),
    .serial_in_in(serial_in_in),
    .image_in(image),
    .cmd_byte_out(cmd_byte),
    .data_byte_out(data_byte),
    .len_ok_out(len_ok),
    .frame_tog_out(frame_tog),
    .serial_out_out(serial_out_out)
  );

  assign image = {stat_q, ctrl_q};
  assign sleep = ctrl_q[3][mds_pkg::SLEEP_BIT];

  // Two-flop synchronisers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      step_meta_q <= 1'b0;
      step_sync_q <= 1'b0;
      step_prev_q <= 1'b0;
      dir_meta_q <= 1'b0;
      dir_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= chip_select_n_in;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      tog_meta_q <= frame_tog;
      tog_sync_q <= tog_meta_q;
      step_meta_q <= step_input_in;
      step_sync_q <= step_meta_q;
      step_prev_q <= step_sync_q;
      dir_meta_q <= direction_in;
      dir_sync_q <= dir_meta_q;
    end
  end

  // Commit decode at select release
  assign cs_rise = cs_sync_q & ~cs_prev_q;
  assign new_frame = tog_sync_q ^ tog_seen_q;
  assign wr_hit = cs_rise & new_frame & len_ok
    & cmd_byte[mds_pkg::OP_BIT]
    & (cmd_byte[mds_pkg::ADDR_MSB:0] < mds_pkg::OFS_STATUS0);
  assign wr_addr = cmd_byte[1:0];
  assign wd_kick = wr_hit && (wr_addr == mds_pkg::OFS_WATCHDOG[1:0])
    && data_byte[mds_pkg::WD_EN_BIT];
  assign wd_boot_clr = wr_hit && (wr_addr == mds_pkg::OFS_WATCHDOG[1:0])
    && !data_byte[mds_pkg::WD_EN_BIT];

  // Frame seen marker, so an empty select pulse commits nothing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_seen_q <= 1'b0;
    end else if (cs_rise) begin
      tog_seen_q <= tog_sync_q;
    end
  end

  // Control registers, one per generated entry
  for (genvar i = 0; i < mds_pkg::NUM_CTRL; i++) begin : g_ctrl
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ctrl_q[i] <= mds_pkg::RST_REG;
      end else if (wr_hit && wr_addr == 2'(i)) begin
        ctrl_q[i] <= data_byte & mds_pkg::CTRL_MASK[i];
      end
    end
  end

  // Status payload with the boot flag merged in
  always_comb begin
    stat_raw = status_bits_in;
    stat_raw[0][mds_pkg::BOOT_FLAG_BIT] = boot_flag_q;
  end

  // Status registers refresh only while deselected
  for (genvar s = 0; s < mds_pkg::NUM_STAT; s++) begin : g_stat
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        stat_q[s] <= mds_pkg::RST_REG;
      end else if (cs_sync_q) begin
        stat_q[s] <= {^stat_raw[s], stat_raw[s]};
      end
    end
  end

  // Watchdog counts units of the time base
  assign wd_unit_done = (wd_unit_q == UC_W'(WD_UNIT_CYC - 1));
  assign wd_expire = (wd_state_q == mds_pkg::WD_RUN) && wd_unit_done
    && (wd_units_q == ctrl_q[0][mds_pkg::WD_TO_MSB:mds_pkg::WD_TO_LSB]);

  // Watchdog state and counters
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_state_q <= mds_pkg::WD_IDLE;
      wd_unit_q <= '0;
      wd_units_q <= 4'h0;
    end else if (wd_kick) begin
      wd_state_q <= mds_pkg::WD_RUN;
      wd_unit_q <= '0;
      wd_units_q <= 4'h0;
    end else begin
      unique case (wd_state_q)
        mds_pkg::WD_IDLE: begin
          wd_unit_q <= '0;
        end
        mds_pkg::WD_RUN: begin
          if (wd_unit_done) begin
            wd_unit_q <= '0;
            wd_units_q <= wd_expire ? 4'h0 : wd_units_q + 4'h1;
          end else begin
            wd_unit_q <= wd_unit_q + UC_W'(1);
          end
        end
        default: begin
          wd_state_q <= mds_pkg::WD_IDLE;
        end
      endcase
    end
  end

  // Timeout pulse and boot flag; a timeout beats a clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watchdog_reset_out <= 1'b0;
      boot_flag_q <= 1'b0;
    end else begin
      watchdog_reset_out <= wd_expire;
      if (wd_expire) begin
        boot_flag_q <= 1'b1;
      end else if (wd_boot_clr) begin
        boot_flag_q <= 1'b0;
      end
    end
  end
  assign boot_flag_out = boot_flag_q;

  // Configuration fields straight from the registers
  assign step_mode_sel_out =
    ctrl_q[1][mds_pkg::SM_MSB:mds_pkg::SM_LSB];
  assign current_amplitude_sel_out =
    ctrl_q[1][mds_pkg::CUR_MSB:mds_pkg::CUR_LSB];
  assign slope_control_out =
    ctrl_q[2][mds_pkg::SLOPE_MSB:mds_pkg::SLOPE_LSB];
  assign sleep_out = sleep;

  // Step edge by programmed polarity
  assign step_edge = ctrl_q[2][mds_pkg::STEP_POL_BIT] ?
    (step_prev_q & ~step_sync_q) : (step_sync_q & ~step_prev_q);

  // Step and direction ignored while asleep; drivers gated
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_pulse_out <= 1'b0;
      direction_out <= 1'b0;
      driver_enable_out <= 1'b0;
    end else begin
      step_pulse_out <= step_edge & ~sleep;
      if (!sleep) begin
        direction_out <= dir_sync_q ^ ctrl_q[2][mds_pkg::DIR_BIT];
      end
      driver_enable_out <= ctrl_q[3][mds_pkg::MOT_EN_BIT] & ~sleep;
    end
  end

  // PWM period: base or halved, plus optional jitter
  always_comb begin
    pwm_limit = ctrl_q[2][mds_pkg::PWM_DBL_BIT] ?
      mds_pkg::PWM_W'(mds_pkg::PWM_CYC / 2 - 1) :
      mds_pkg::PWM_W'(mds_pkg::PWM_CYC - 1);
    if (ctrl_q[2][mds_pkg::PWM_JIT_BIT]) begin
      pwm_limit = pwm_limit + {8'h00, lfsr_q[3:0]};
    end
  end

  // PWM time base, silent in sleep
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_cnt_q <= '0;
      pwm_tick_out <= 1'b0;
      lfsr_q <= 8'h01;
    end else if (sleep) begin
      pwm_cnt_q <= '0;
      pwm_tick_out <= 1'b0;
    end else if (pwm_cnt_q >= pwm_limit) begin
      pwm_cnt_q <= '0;
      pwm_tick_out <= 1'b1;
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end else begin
      pwm_cnt_q <= pwm_cnt_q + mds_pkg::PWM_W'(1);
      pwm_tick_out <= 1'b0;
    end
  end

  // Load angle scaled by the gain setting
  assign la_scaled = ctrl_q[3][mds_pkg::LA_GAIN_BIT] ?
    (load_angle_in >> mds_pkg::LA_SHIFT_QUARTER) :
    (load_angle_in >> mds_pkg::LA_SHIFT_HALF);

  // Follows each cycle, or samples only on steps when held
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_angle_output_out <= '0;
    end else if (!ctrl_q[3][mds_pkg::LA_HOLD_BIT] || step_pulse_out) begin
      load_angle_output_out <= la_scaled;
    end
  end

  // Output enable follows the synchronised select
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_out_en_out <= 1'b0;
    end else begin
      serial_out_en_out <= ~cs_sync_q;
    end
  end

  // Control bank changes only right after a select release
  commit_timing_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !$stable(ctrl_q) |-> $past(cs_rise))
    else $error("control register changed outside a commit");

  // Wrong length leaves the bank untouched
  length_gate_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !len_ok) |=> $stable(ctrl_q))
    else $error("write of wrong length committed");

  // Writes to status addresses change nothing
  readonly_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && cmd_byte[mds_pkg::ADDR_MSB:2] != 3'h0) |=> $stable(ctrl_q))
    else $error("read-only address altered control bank");

  // Status frozen while selected
  status_freeze_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !cs_sync_q |=> $stable(stat_q))
    else $error("status changed while selected");

  // Kick restarts the count from zero
  watchdog_kick_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wd_kick |=> (wd_state_q == mds_pkg::WD_RUN) && wd_unit_q == '0
      && wd_units_q == 4'h0)
    else $error("watchdog not restarted by enable write");

  // Enable written zero clears the boot flag
  boot_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wd_boot_clr && !wd_expire) |=> !boot_flag_out)
    else $error("boot flag not cleared");

  // Timeout fires after setting plus one units
  timeout_units_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    watchdog_reset_out |-> $past(wd_units_q)
      == $past(ctrl_q[0][mds_pkg::WD_TO_MSB:mds_pkg::WD_TO_LSB]))
    else $error("watchdog timeout at wrong unit count");

  // No step pulse follows a cycle spent asleep
  sleep_step_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    sleep |=> !step_pulse_out)
    else $error("step pulse while asleep");

  // Driver enable tracks motor enable and sleep
  driver_gate_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ##1 driver_enable_out ==
      $past(ctrl_q[3][mds_pkg::MOT_EN_BIT] & ~sleep))
    else $error("driver enable mismatch");

  // Transparent load angle follows scaled input
  angle_follow_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_q[3][mds_pkg::LA_HOLD_BIT] |=>
      load_angle_output_out == $past(la_scaled))
    else $error("load angle output not transparent");

endmodule

// File: tb/mds_spi_master.sv
// Purpose: Serial master model on the far side of the link
// Assumes: Mode 0, MSB first, 125 ns link period
// Notes:   Link clock stands still low outside frames
`timescale 1ns/10ps
module mds_spi_master (
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  localparam real HALF_NS = 62.5; // Half link period
  // Idle levels before any frame
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // One frame of nbits, sent from tx[nbits-1] down
  task automatic xfer(input int nbits, input logic [23:0] tx,
                      output logic [23:0] rx);
    rx = 24'h000000;
    #(HALF_NS + 3.0);
    cs_n_out = 1'b0;
    #(2 * HALF_NS);
    for (int i = nbits - 1; i >= 0; i--) begin
      // First bit of byte one picks the operation
      mosi_out = tx[i];
      #(HALF_NS);
      sclk_out = 1'b1;
      // Every returned bit kept; rd and wr check byte two only
      rx = {rx[22:0], miso_in};
      #(HALF_NS);
      sclk_out = 1'b0;
    end
    #(HALF_NS);
    cs_n_out = 1'b1;
    // Released line no longer holds its last bit
    mosi_out = ~mosi_out;
    #(8 * HALF_NS);
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the serial register block
// Assumes: Watchdog unit shortened to 40 cycles
// Notes:   Expected registers come from a mask model
`timescale 1ns/10ps
module testbench;
  logic clk_in, rst_n_in, sclk, cs_n, mosi, dout, dout_en, miso;
  logic [27:0] status; // Status payload
  logic [2:0] sm;
  logic [4:0] cur;
  logic [1:0] slope;
  logic slp, drv_en, wd_rst, boot;
  logic stp, dir, stp_out, dir_out, tick; // Step pin side
  logic [7:0] la, la_out; // Load angle in and out
  logic [31:0] lfsr_q; // Stimulus generator state
  logic [23:0] rx; // Bits of the last frame
  int num_errors, tests_run, cycles, old, n;
  int regs[4]; // Expected control registers
  int mask[4] = '{32'hF8, 32'hFF, 32'hF3, 32'hF0}; // Writable bits
  // Pull-up while the output is released
  assign miso = dout_en ? dout : 1'b1;
  mds_spi_master u_m (.miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));
  mds_motor_spi_regs #(.WD_UNIT_CYC(40), .LA_W(8)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .chip_select_n_in(cs_n), .serial_in_in(mosi), .step_input_in(stp),
    .direction_in(dir), .load_angle_in(la), .status_bits_in(status),
    .serial_out_out(dout), .serial_out_en_out(dout_en),
    .step_mode_sel_out(sm), .current_amplitude_sel_out(cur),
    .slope_control_out(slope), .step_pulse_out(stp_out),
    .direction_out(dir_out), .pwm_tick_out(tick), .sleep_out(slp),
    .driver_enable_out(drv_en), .load_angle_output_out(la_out),
    .watchdog_reset_out(wd_rst),
    .boot_flag_out(boot));
  // System clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Cycle budget against a hang
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      num_errors++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read frame; byte two is the addressed register
  task automatic rd(input int a, input int e);
    u_m.xfer(16, {8'h00, 3'b000, a[4:0], 8'h00}, rx);
    check(rx[7:0], e[7:0]);
  endtask
  // Write frame; byte two returns the old contents
  task automatic wr(input int a, input logic [7:0] d);
    u_m.xfer(16, {8'h00, 3'b100, a[4:0], d}, rx);
    if (a < 4) begin
      check(rx[7:0], regs[a][7:0]);
      regs[a] = d & mask[a];
    end
  endtask
  // Register fields as seen on the outputs
  task automatic chk_out();
    #1;
    check({sm, cur}, regs[1][7:0]);
    check({slp, drv_en, slope, 4'h0}, {regs[3][6],
      regs[3][7] & ~regs[3][6], regs[2][1:0], 4'h0});
    check({7'h00, dout_en}, 8'h00);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    status = 28'h0000000;
    {stp, dir, la} = 10'h000;
    lfsr_q = 32'hFF1D;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    status <= lfsr_q[27:0];
    repeat (4) @(posedge clk_in);
    for (int a = 0; a < 4; a++) begin
      rd(a, 0);
    end
    rd(9, 0);
    $display("test reset values done");
    for (int a = 0; a < 4; a++) begin
      old = regs[a];
      lfsr_q = lfsr_next(lfsr_q);
      wr(a, lfsr_q[7:0]);
      rd(a, regs[a]);
      check(rx[15:8], old[7:0]);
      chk_out();
    end
    $display("test write and read back done");
    old = regs[1];
    fork
      wr(1, 8'h3C);
      begin
        @(negedge cs_n);
        repeat (86) @(posedge clk_in);
        #1;
        check({sm, cur}, old[7:0]);
      end
    join
    chk_out();
    $display("test commit on release done");
    u_m.xfer(15, {9'h000, 8'h81, 7'h2A}, rx); // Short frame
    u_m.xfer(17, {7'h00, 8'h81, 8'hD5, 1'b1}, rx); // Long frame
    u_m.xfer(16, {8'h00, 8'h01, 8'hC3}, rx); // Read op with data
    wr(5, 8'hFF);
    rd(5, {^status[13:7], status[13:7]});
    rd(1, regs[1]);
    chk_out();
    $display("test refused frames done");
    wr(0, 8'hF8);
    n = 0;
    while (wd_rst !== 1'b1 && n < 1000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({7'h00, n >= 610 && n <= 635}, 8'h01);
    check({7'h00, boot}, 8'h01);
    wr(0, 8'h78);
    check({7'h00, boot}, 8'h00);
    $display("test watchdog done");
    wr(2, 8'hA0);
    wr(3, 8'hA0);
    chk_out();
    lfsr_q = lfsr_next(lfsr_q);
    @(posedge clk_in);
    la <= lfsr_q[7:0];
    repeat (2) @(posedge clk_in);
    #1;
    check(la_out, la / 8'h04);
    check({7'h00, dir_out}, 8'h01);
    n = 0;
    while (tick !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 2000);
    check({7'h00, n == mds_pkg::PWM_CYC / 2}, 8'h01);
    wr(3, 8'hB0);
    old = la;
    @(posedge clk_in);
    la <= ~la;
    stp <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check({7'h00, stp_out}, 8'h01);
    check(la_out, old[7:0] / 8'h04);
    @(posedge clk_in);
    #1;
    check(la_out, la / 8'h04);
    wr(3, 8'hF0);
    chk_out();
    n = 0;
    @(posedge clk_in);
    stp <= 1'b0;
    repeat (4) @(posedge clk_in);
    stp <= 1'b1;
    repeat (6) begin
      @(posedge clk_in);
      #1;
      n += stp_out;
    end
    check(n[7:0], 8'h00);
    $display("test motion controls done");
    summarize();
  end
endmodule
